// File: pva_regs.svh
// What this block does
// RULE1: Release hysteresis accepted from 1 to 200 counts, used by absolute and deviation alarms.
// RULE2: Software keeps hysteresis strictly below the deviation threshold amount.
// RULE3: A threshold alarm sets in the same evaluation the value first passes it.
// RULE4: An alarm clears only once the value is back past threshold by the hysteresis.
// RULE5: Programming error unless low-low < low < high < high-high.
// RULE6: Programming error also when yellow deviation is not below red deviation.
// RULE7: Calculation error when output sits at a limit and value misses setpoint.
// RULE8: Deviation thresholds apply equally above and below the moving setpoint.
// RULE9: Deviation alarms work only in automatic mode and need control bit 13.
// RULE10: Rate-of-change alarm needs control bit 14 and has no hysteresis.
// RULE11: All checks run once per sample period; status bits update together.
`ifndef PVA_REGS_SVH
`define PVA_REGS_SVH

// ==========================================================================
// Register byte offsets
`define PVA_OFS_CTRL       32'h0000_0000
`define PVA_OFS_SETPOINT   32'h0000_0004
`define PVA_OFS_PROC_VAL   32'h0000_0008
`define PVA_OFS_LOW_LOW    32'h0000_000C
`define PVA_OFS_LOW        32'h0000_0010
`define PVA_OFS_HIGH       32'h0000_0014
`define PVA_OFS_HIGH_HIGH  32'h0000_0018
`define PVA_OFS_DEV_YELLOW 32'h0000_001C
`define PVA_OFS_DEV_RED    32'h0000_0020
`define PVA_OFS_RATE       32'h0000_0024
`define PVA_OFS_HYST       32'h0000_0028
`define PVA_OFS_OUTPUT     32'h0000_002C
`define PVA_OFS_OUT_LOW    32'h0000_0030
`define PVA_OFS_OUT_HIGH   32'h0000_0034
`define PVA_OFS_PERIOD     32'h0000_0038
`define PVA_OFS_STATUS     32'h0000_003C

// ==========================================================================
// Register indices (byte offset / 4)
`define PVA_IDX_CTRL       4'h0
`define PVA_IDX_SETPOINT   4'h1
`define PVA_IDX_PROC_VAL   4'h2
`define PVA_IDX_LOW_LOW    4'h3
`define PVA_IDX_LOW        4'h4
`define PVA_IDX_HIGH       4'h5
`define PVA_IDX_HIGH_HIGH  4'h6
`define PVA_IDX_DEV_YELLOW 4'h7
`define PVA_IDX_DEV_RED    4'h8
`define PVA_IDX_RATE       4'h9
`define PVA_IDX_HYST       4'hA
`define PVA_IDX_OUTPUT     4'hB
`define PVA_IDX_OUT_LOW    4'hC
`define PVA_IDX_OUT_HIGH   4'hD
`define PVA_IDX_PERIOD     4'hE
`define PVA_IDX_STATUS     4'hF

// ==========================================================================
// Control fields
`define PVA_CTRL_ABS_EN    0
`define PVA_CTRL_AUTO      1
`define PVA_CTRL_DEV_EN    13
`define PVA_CTRL_RATE_EN   14
`define PVA_CTRL_MASK      32'h0000_6003
`define PVA_DATA_MASK      32'h0000_FFFF

// Status fields
`define PVA_ST_LOW_LOW     0
`define PVA_ST_LOW         1
`define PVA_ST_HIGH        2
`define PVA_ST_HIGH_HIGH   3
`define PVA_ST_YELLOW      4
`define PVA_ST_RED         5
`define PVA_ST_RATE        6
`define PVA_ST_PROG_ERR    7
`define PVA_ST_CALC_ERR    8

// ==========================================================================
// Reset values and limits
`define PVA_RST_ZERO       32'h0000_0000
`define PVA_RST_HYST       32'h0000_0001
`define PVA_RST_PERIOD     32'h0000_0064
`define PVA_HYST_MIN       16'h0001
`define PVA_HYST_MAX       16'h00C8
`define PVA_RESP_OKAY      2'h0
`define PVA_RESP_SLVERR    2'h2

`endif

// File: pva_pkg.sv
`default_nettype none
package pva_pkg;
  typedef logic [15:0] pva_val_t;
  typedef logic [8:0]  pva_status_t;
  typedef enum logic [1:0] {RD_IDLE, RD_ADDR, RD_DATA} pva_rd_e;
  typedef enum logic [1:0] {WR_IDLE, WR_ACCEPT, WR_RESP} pva_wr_e;
endpackage : pva_pkg
`default_nettype wire

// File: pva_alarm_checker.sv
`include "pva_regs.svh"
`default_nettype none
module pva_alarm_checker (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [31:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [31:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [8:0]       alarm_status,
  output logic             eval_done
);

  // ==========================================================================
  // Helper functions

  // Mask of implemented bits for a register index
  function automatic logic [31:0] reg_mask(input logic [3:0] idx);
    logic [31:0] m;
    begin
      m = `PVA_DATA_MASK;
      if (idx == `PVA_IDX_CTRL) begin
        m = `PVA_CTRL_MASK;
      end else if (idx == `PVA_IDX_PERIOD) begin
        m = 32'hFFFF_FFFF;
      end
      reg_mask = m;
    end
  endfunction : reg_mask

  // Address lies in the register window
  function automatic logic addr_ok(input logic [31:0] addr);
    addr_ok = (addr[31:6] == 26'h0);
  endfunction : addr_ok

  // Merge write data by byte strobes
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] r;
    begin
      r = old_v;
      for (int b = 0; b < 4; b++) begin
        if (strb[b]) begin
          r[b*8 +: 8] = new_v[b*8 +: 8];
        end
      end
      merge_strb = r;
    end
  endfunction : merge_strb

  // Upper alarm with release hysteresis
  function automatic logic hi_alarm(input logic        held,
                                    input logic [16:0] val,
                                    input logic [16:0] thr,
                                    input logic [15:0] hyst);
    logic signed [18:0] v;
    logic signed [18:0] t;
    logic signed [18:0] h;
    begin
      v = $signed({2'b00, val});
      t = $signed({2'b00, thr});
      h = $signed({3'b000, hyst});
      hi_alarm = (v > t) || (held && (v > (t - h))); // RULE3 RULE4
    end
  endfunction : hi_alarm

  // Lower alarm with release hysteresis
  function automatic logic lo_alarm(input logic        held,
                                    input logic [16:0] val,
                                    input logic [16:0] thr,
                                    input logic [15:0] hyst);
    logic signed [18:0] v;
    logic signed [18:0] t;
    logic signed [18:0] h;
    begin
      v = $signed({2'b00, val});
      t = $signed({2'b00, thr});
      h = $signed({3'b000, hyst});
      lo_alarm = (v < t) || (held && (v < (t + h))); // RULE3 RULE4
    end
  endfunction : lo_alarm

  // Magnitude of the difference of two values
  function automatic logic [16:0] abs_diff(input logic [15:0] a, input logic [15:0] b);
    abs_diff = (a >= b) ? {1'b0, a - b} : {1'b0, b - a};
  endfunction : abs_diff

  // ==========================================================================
  // Register storage and bus state
  logic [31:0]         regs_q [15];
  pva_pkg::pva_status_t status_q;
  pva_pkg::pva_wr_e    wr_state_q;
  pva_pkg::pva_rd_e    rd_state_q;
  logic                awready_q;
  logic                wready_q;
  logic                aw_held_q;
  logic                w_held_q;
  logic [31:0]         waddr_q;
  logic [31:0]         wdata_q;
  logic [3:0]          wstrb_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                arready_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic [31:0]         tick_cnt_q;
  logic                eval_done_q;
  pva_pkg::pva_val_t   prev_pv_q;
  logic                prev_ok_q;

  // ==========================================================================
  // Bus decode
  wire        aw_take   = s_axi_awvalid && awready_q;
  wire        w_take    = s_axi_wvalid && wready_q;
  wire        do_write  = aw_held_q && w_held_q && (wr_state_q == pva_pkg::WR_ACCEPT);
  wire [3:0]  widx      = waddr_q[5:2];
  wire        w_legal   = addr_ok(waddr_q) && (widx != `PVA_IDX_STATUS);
  wire [3:0]  ridx      = s_axi_araddr[5:2];
  wire        r_legal   = addr_ok(s_axi_araddr);
  wire [31:0] rd_word   = (ridx == `PVA_IDX_STATUS) ? {23'h0, status_q}
                                                    : (regs_q[ridx] & reg_mask(ridx));

  // ==========================================================================
  // Write channel: take address and data in any order, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_q <= pva_pkg::WR_IDLE;
      awready_q  <= 1'b0;
      wready_q   <= 1'b0;
      aw_held_q  <= 1'b0;
      w_held_q   <= 1'b0;
      waddr_q    <= `PVA_RST_ZERO;
      wdata_q    <= `PVA_RST_ZERO;
      wstrb_q    <= 4'h0;
      bvalid_q   <= 1'b0;
      bresp_q    <= `PVA_RESP_OKAY;
    end else begin
      awready_q <= s_axi_awvalid && !awready_q && !aw_held_q && !bvalid_q;
      wready_q  <= s_axi_wvalid && !wready_q && !w_held_q && !bvalid_q;
      if (aw_take) begin
        aw_held_q <= 1'b1;
        waddr_q   <= s_axi_awaddr;
      end
      if (w_take) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      case (wr_state_q)
        pva_pkg::WR_IDLE: begin
          wr_state_q <= pva_pkg::WR_ACCEPT;
        end
        pva_pkg::WR_ACCEPT: begin
          if (do_write) begin
            aw_held_q  <= 1'b0;
            w_held_q   <= 1'b0;
            bvalid_q   <= 1'b1;
            bresp_q    <= w_legal ? `PVA_RESP_OKAY : `PVA_RESP_SLVERR;
            wr_state_q <= pva_pkg::WR_RESP;
          end
        end
        pva_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            bvalid_q   <= 1'b0;
            wr_state_q <= pva_pkg::WR_ACCEPT;
          end
        end
        default: begin
          wr_state_q <= pva_pkg::WR_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Writable registers, one per index
  for (genvar i = 0; i < 15; i++) begin : g_reg
    localparam logic [3:0] IDX = 4'(i);
    wire [31:0] rst_v = (IDX == `PVA_IDX_HYST)   ? `PVA_RST_HYST :
                        (IDX == `PVA_IDX_PERIOD) ? `PVA_RST_PERIOD : `PVA_RST_ZERO;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        regs_q[i] <= rst_v;
      end else if (do_write && w_legal && (widx == IDX)) begin
        regs_q[i] <= merge_strb(regs_q[i], wdata_q, wstrb_q) & reg_mask(IDX);
      end
    end
  end

  // ==========================================================================
  // Read channel: address pulse then data until taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_q <= pva_pkg::RD_IDLE;
      arready_q  <= 1'b0;
      rvalid_q   <= 1'b0;
      rdata_q    <= `PVA_RST_ZERO;
      rresp_q    <= `PVA_RESP_OKAY;
    end else begin
      case (rd_state_q)
        pva_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            arready_q  <= 1'b1;
            rd_state_q <= pva_pkg::RD_ADDR;
          end
        end
        pva_pkg::RD_ADDR: begin
          arready_q  <= 1'b0;
          rvalid_q   <= 1'b1;
          rdata_q    <= r_legal ? rd_word : `PVA_RST_ZERO;
          rresp_q    <= r_legal ? `PVA_RESP_OKAY : `PVA_RESP_SLVERR;
          rd_state_q <= pva_pkg::RD_DATA;
        end
        pva_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rvalid_q   <= 1'b0;
            rd_state_q <= pva_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= pva_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Field views of the configuration
  wire [31:0]             ctrl     = regs_q[`PVA_IDX_CTRL];
  wire                    abs_en   = ctrl[`PVA_CTRL_ABS_EN];
  wire                    dev_on   = ctrl[`PVA_CTRL_DEV_EN] && ctrl[`PVA_CTRL_AUTO]; // RULE9
  wire                    rate_on  = ctrl[`PVA_CTRL_RATE_EN]; // RULE10
  wire pva_pkg::pva_val_t sp       = regs_q[`PVA_IDX_SETPOINT][15:0];
  wire pva_pkg::pva_val_t pv       = regs_q[`PVA_IDX_PROC_VAL][15:0];
  wire pva_pkg::pva_val_t thr_ll   = regs_q[`PVA_IDX_LOW_LOW][15:0];
  wire pva_pkg::pva_val_t thr_l    = regs_q[`PVA_IDX_LOW][15:0];
  wire pva_pkg::pva_val_t thr_h    = regs_q[`PVA_IDX_HIGH][15:0];
  wire pva_pkg::pva_val_t thr_hh   = regs_q[`PVA_IDX_HIGH_HIGH][15:0];
  wire pva_pkg::pva_val_t dev_yel  = regs_q[`PVA_IDX_DEV_YELLOW][15:0];
  wire pva_pkg::pva_val_t dev_red  = regs_q[`PVA_IDX_DEV_RED][15:0];
  wire pva_pkg::pva_val_t rate_lim = regs_q[`PVA_IDX_RATE][15:0];
  wire pva_pkg::pva_val_t hyst_raw = regs_q[`PVA_IDX_HYST][15:0];
  wire pva_pkg::pva_val_t out_val  = regs_q[`PVA_IDX_OUTPUT][15:0];
  wire pva_pkg::pva_val_t out_lo   = regs_q[`PVA_IDX_OUT_LOW][15:0];
  wire pva_pkg::pva_val_t out_hi   = regs_q[`PVA_IDX_OUT_HIGH][15:0];
  wire [31:0]             period   = regs_q[`PVA_IDX_PERIOD];

  // Hysteresis held inside its legal span
  wire pva_pkg::pva_val_t hyst = (hyst_raw < `PVA_HYST_MIN) ? `PVA_HYST_MIN :
                                 (hyst_raw > `PVA_HYST_MAX) ? `PVA_HYST_MAX : hyst_raw; // RULE1

  // ==========================================================================
  // Sample tick, period zero acts as one cycle
  wire tick = (tick_cnt_q + 32'h1 >= period); // RULE11

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= `PVA_RST_ZERO;
    end else begin
      tick_cnt_q <= tick ? `PVA_RST_ZERO : tick_cnt_q + 32'h1;
    end
  end

  // ==========================================================================
  // Alarm evaluation terms
  wire [16:0] pv_x    = {1'b0, pv};
  wire [16:0] dev_mag = abs_diff(pv, sp); // RULE8
  wire [16:0] pv_step = abs_diff(pv, prev_pv_q);

  wire a_ll  = abs_en && lo_alarm(status_q[`PVA_ST_LOW_LOW], pv_x, {1'b0, thr_ll}, hyst);
  wire a_l   = abs_en && lo_alarm(status_q[`PVA_ST_LOW], pv_x, {1'b0, thr_l}, hyst);
  wire a_h   = abs_en && hi_alarm(status_q[`PVA_ST_HIGH], pv_x, {1'b0, thr_h}, hyst);
  wire a_hh  = abs_en && hi_alarm(status_q[`PVA_ST_HIGH_HIGH], pv_x, {1'b0, thr_hh}, hyst);
  wire a_yel = dev_on && hi_alarm(status_q[`PVA_ST_YELLOW], dev_mag, {1'b0, dev_yel}, hyst); // RULE8
  wire a_red = dev_on && hi_alarm(status_q[`PVA_ST_RED], dev_mag, {1'b0, dev_red}, hyst); // RULE8
  wire a_rate = rate_on && prev_ok_q && (pv_step > {1'b0, rate_lim}); // RULE10

  // Threshold ordering and output limit checks
  wire abs_bad  = !((thr_ll < thr_l) && (thr_l < thr_h) && (thr_h < thr_hh)); // RULE5
  wire dev_bad  = !(dev_yel < dev_red); // RULE6
  wire at_limit = (out_val >= out_hi) || (out_val <= out_lo);
  wire calc_bad = at_limit && (pv != sp); // RULE7

  wire [8:0] status_d = {calc_bad, abs_bad || dev_bad, a_rate, a_red, a_yel,
                         a_hh, a_h, a_l, a_ll};

  // ==========================================================================
  // Status update, all bits at once on the tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_q    <= 9'h000;
      prev_pv_q   <= 16'h0000;
      prev_ok_q   <= 1'b0;
      eval_done_q <= 1'b0;
    end else begin
      eval_done_q <= tick;
      if (tick) begin
        status_q  <= status_d; // RULE11
        prev_pv_q <= pv;
        prev_ok_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign alarm_status  = status_q;
  assign eval_done     = eval_done_q;

endmodule : pva_alarm_checker
`default_nettype wire

// File: pva_alarm_checker_assertions.sv
`include "pva_regs.svh"
`default_nettype none
module pva_alarm_checker_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [8:0]  alarm_status,
  input wire logic        eval_done
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Bus handshake
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped early");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped early");
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  chk_b_blocks: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while response pending");
  chk_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp inside {`PVA_RESP_OKAY,
    `PVA_RESP_SLVERR}) else $error("illegal write response");
  chk_err_zero: assert property (s_axi_rvalid && s_axi_rresp == `PVA_RESP_SLVERR |->
    s_axi_rdata == 32'h0000_0000) else $error("error read carries data");
  // ==========================================================
  // Reset and evaluation
  chk_reset_quiet: assert property (disable iff (1'b0) !aresetn |=> !s_axi_bvalid &&
    !s_axi_rvalid && alarm_status == 9'h000 && !eval_done) else $error("active in reset");
  chk_status_eval: assert property (!$stable(alarm_status) |-> ##[0:1] eval_done)
    else $error("status moved outside evaluation");
endmodule : pva_alarm_checker_assertions
`default_nettype wire

// File: pva_alarm_checker_tb_top.sv
`include "pva_regs.svh"
`default_nettype none
module pva_alarm_checker_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [8:0]  alarm_status;
  logic        eval_done;
  logic [33:0] exp_r [$];
  logic [1:0]  exp_b [$];
  logic [8:0]  exp_s [$];
  logic        lazy = 1'b0;
  logic [16:0] r [16];
  logic [8:0]  prv = 9'h000;
  logic [16:0] ppv = 17'h0;
  logic [31:0] seed = 32'h4FE1;
  int          err_total = 0, compares = 0, cyc = 0;
  // Step table: register index in the top nibble, value below
  localparam logic [19:0] ST [43] = '{20'h3_0100, 20'h4_0200, 20'h5_0800, 20'h6_0900,
    20'h7_0040, 20'h8_0080, 20'h4_0800, 20'h4_0200, 20'h5_0A00, 20'h5_0800, 20'h7_0080,
    20'h7_0030, 20'h8_0030, 20'h8_0080, 20'h3_0200, 20'h3_0100, 20'hC_0100, 20'hD_0F00,
    20'h1_0500, 20'h2_0400, 20'hB_0100, 20'hB_00FF, 20'hB_0800, 20'hB_0F00, 20'h2_0500,
    20'hB_0800, 20'h0_0001, 20'h0_6002, 20'h9_0010, 20'hA_0001, 20'h2_0500, 20'h2_0541,
    20'h2_0500, 20'h2_04BF, 20'h2_0581, 20'h2_047F, 20'h2_0540, 20'h0_4002, 20'h0_2002,
    20'h0_2000, 20'h0_6002, 20'h1_0700, 20'h2_0741};
  localparam logic [15:0] HY [3] = '{16'h00C8, 16'h012C, 16'h0000};
  localparam logic [15:0] PV [11] = '{16'h0801, 16'h0800, 16'h0739, 16'h0738, 16'h0901,
    16'h0500, 16'h01FF, 16'h02C7, 16'h02C8, 16'h00FF, 16'h0500};

  pva_alarm_checker i_pva_alarm_checker (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alarm_status, .eval_done);

  // ==========================================================
  // Clock, timeout and result monitor
  always #2 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      summarize();
    end
  end
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready) cmp_rd(exp_r.pop_front());
    if (s_axi_bvalid && s_axi_bready) cmp_b(exp_b.pop_front());
    if (s_axi_rvalid && s_axi_rready && s_axi_araddr == `PVA_OFS_STATUS && exp_s.size() > 0)
      cmp_st(exp_s.pop_front());
  end

  // ==========================================================
  // Compare, bus and model helpers
  task automatic cmp_rd(input logic [33:0] e);
    compares++;
    if ({s_axi_rresp, s_axi_rdata} !== e) begin
      err_total++;
      $display("Error read expected %h seen %h", e, {s_axi_rresp, s_axi_rdata});
    end
  endtask : cmp_rd
  task automatic cmp_b(input logic [1:0] e);
    compares++;
    if (s_axi_bresp !== e) begin
      err_total++;
      $display("Error bresp expected %h seen %h", e, s_axi_bresp);
    end
  endtask : cmp_b
  task automatic cmp_st(input logic [8:0] e);
    compares++;
    if (alarm_status !== e) begin
      err_total++;
      $display("Error alarm_status expected %h seen %h", e, alarm_status);
    end
  endtask : cmp_st
  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] e);
    exp_b.push_back(e);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= !lazy;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && !s_axi_bready) s_axi_bready <= 1'b1;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [31:0] a, input logic [33:0] e);
    exp_r.push_back(e);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= !lazy;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && !s_axi_rready) s_axi_rready <= 1'b1;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic wreg(input int i, input logic [31:0] d);
    wr(32'(i * 4), d, `PVA_RESP_OKAY);
    r[i] = {1'b0, (i == 0) ? d[15:0] & 16'h6003 : d[15:0]};
  endtask : wreg
  function automatic logic [8:0] model();
    logic [16:0] h, v, d, q;
    logic [8:0]  s;
    h = (r[10] == 17'h0) ? 17'h1 : (r[10] > 17'hC8) ? 17'hC8 : r[10];
    v = r[2];
    d = (v > r[1]) ? v - r[1] : r[1] - v;
    q = (v > ppv) ? v - ppv : ppv - v;
    s[0] = r[0][0] && (prv[0] ? v < r[3] + h : v < r[3]);
    s[1] = r[0][0] && (prv[1] ? v < r[4] + h : v < r[4]);
    s[2] = r[0][0] && (prv[2] ? v + h > r[5] : v > r[5]);
    s[3] = r[0][0] && (prv[3] ? v + h > r[6] : v > r[6]);
    s[4] = r[0][13] && r[0][1] && (prv[4] ? d + h > r[7] : d > r[7]);
    s[5] = r[0][13] && r[0][1] && (prv[5] ? d + h > r[8] : d > r[8]);
    s[6] = r[0][14] && q > r[9];
    s[7] = !(r[3] < r[4] && r[4] < r[5] && r[5] < r[6] && r[7] < r[8]);
    s[8] = (r[11] >= r[13] || r[11] <= r[12]) && v != r[1];
    return s;
  endfunction : model
  // One write between two evaluations, then status of the second one
  task automatic st(input int i, input logic [31:0] d);
    @(posedge aclk iff eval_done);
    wreg(i, d);
    @(posedge aclk iff eval_done);
    prv = model();
    ppv = r[2];
    exp_s.push_back(prv);
    rd(`PVA_OFS_STATUS, {25'h0, prv});
  endtask : st
  task automatic run(input int a, input int b);
    for (int j = a; j <= b; j++) st(int'(ST[j][19:16]), {16'h0, ST[j][15:0]});
  endtask : run
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : summarize

  // ==========================================================
  // Main sequence
  initial begin
    foreach (r[i]) r[i] = 17'h0;
    r[10] = 17'h1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (int i = 15; i >= 0; i--) begin
      rd(32'(i * 4), {2'h0, (i == 10) ? `PVA_RST_HYST : (i == 14) ? `PVA_RST_PERIOD : 32'h0});
    end
    // Late ready on the error accesses, answer must stand
    lazy = 1'b1;
    rd(32'h0000_0040, {`PVA_RESP_SLVERR, 32'h0});
    wr(32'h0000_0040, 32'h1, `PVA_RESP_SLVERR);
    wr(`PVA_OFS_STATUS, 32'h1FF, `PVA_RESP_SLVERR);
    lazy = 1'b0;
    wreg(0, 32'hFFFF_FFFF);
    rd(`PVA_OFS_CTRL, {2'h0, 32'h0000_6003});
    wreg(3, 32'hABCD_1234);
    rd(`PVA_OFS_LOW_LOW, {2'h0, 32'h0000_1234});
    // One byte lane only
    s_axi_wstrb <= 4'h2;
    wr(`PVA_OFS_LOW_LOW, 32'hFFFF_56FF, `PVA_RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rd(`PVA_OFS_LOW_LOW, {2'h0, 32'h0000_5634});
    wreg(0, 32'h0);
    wreg(3, 32'h0);
    $display("Test registers done");
    run(0, 15);
    $display("Test ordering done");
    run(16, 26);
    $display("Test output limit done");
    for (int k = 0; k < 3; k++) begin
      st(10, {16'h0, HY[k]});
      for (int j = 0; j < 11; j++) st(2, {16'h0, PV[j]});
    end
    for (int j = 0; j < 10; j++) begin
      seed = lfsr(seed);
      st(2, seed % 32'hA00);
    end
    $display("Test absolute done");
    run(27, 42);
    $display("Test deviation done");
    summarize();
  end
endmodule : pva_alarm_checker_tb_top

bind pva_alarm_checker pva_alarm_checker_assertions i_pva_alarm_checker_assertions (
  .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .alarm_status, .eval_done);
`default_nettype wire
